// ==== rvp_stage.sv ====
// Railway voltage protection stage: pick-up, blocking, timers, events, counters
// Contract
// - Over or under pick-up mode selectable, over by default.
// - Over mode releases only below 97 percent of pick-up level.
// - Under mode releases only above 103 percent of pick-up level.
// - Input taken from one of four channels, coded 1 to 4, default first.
// - Comparator works on RMS values updated every 5 ms.
// - Keep 20 ms averaged history ending 20 ms before start or trip.
// - Pick-up level 0 to 150 percent in 0.01 percent steps, default 20.
// - Trip pulse length 0 to 1800 s in 5 ms steps, default 100 ms.
// - With forcing enabled, static setting overrides status to normal/start/trip/blocked.
// - Eight setting groups from one selector, changes take effect while running.
// - Under mode with nonzero de-energised level: no trip below that level.
// - De-energised block holds until all channels reach the pick-up level.
// - De-energised level zero disables that blocking; zero is default.
// - Pick-up gives start only while blocking is inactive.
// - Block sampled each processing cycle; unblocked pick-up starts operate timing.
// - Block active at pick-up gives blocked and no further start or trip.
// - Block arriving during start withdraws start and runs release handling; the code instead drops start and clears both timers at once.
// - Time-stamped on and off events for start, trip, blocked at 1 ms.
// - Instant mode start and trip events share one time stamp.
// - Resettable cumulative counters of start, trip and blocked.
// - Block activation raises display event and blocking event with voltage, fault type.
// - Operate delay zero trips instantly; nonzero delays trip accordingly.
// - Delayed release holds start for the release time, default 60 ms.
// - Timer-reset-after-release clears operate count only after the release time.
`timescale 1ns/1ps
`include "rvp_cfg.svh"
module rvp_stage #(
  parameter int VW = 24,
  parameter int CYCLE_CLKS = `RVP_CYCLE_MS * `RVP_CLK_KHZ,
  parameter int STAMP_CLKS = `RVP_STAMP_MS * `RVP_CLK_KHZ,
  parameter int GROUPS = `RVP_GROUPS,
  parameter int PREF_N = `RVP_PREF_SAMPLES
) (
  input wire logic core_clk,                 // System clock, 100 MHz
  input wire logic rstn,                     // Synchronous reset, active low
  input wire logic [VW-1:0] voltage_channel_a, // RMS voltage, 0.01 percent Un units
  input wire logic [VW-1:0] voltage_channel_b, // RMS voltage, 0.01 percent Un units
  input wire logic [VW-1:0] voltage_channel_c, // RMS voltage, 0.01 percent Un units
  input wire logic [VW-1:0] voltage_channel_d, // RMS voltage, 0.01 percent Un units
  input wire logic [2:0] channel_sel,        // Static channel select, 1 to 4
  input wire logic block_in,                 // External block from blocking matrix
  input wire logic force_enable,             // Global stage forcing enable
  input wire logic [1:0] status_override,    // Forced status code
  input wire logic [2:0] group_sel,          // Active setting group
  input wire logic cfg_wr,                   // Write strobe for one setting group
  input wire logic [2:0] cfg_group,          // Group written by cfg_wr
  input wire logic [1:0] cfg_mode,           // 1 over, 2 under
  input wire logic [15:0] cfg_pickup_level,  // Pick-up level, 0.01 percent Un
  input wire logic [15:0] cfg_deenergised_block_level, // De-energised level
  input wire logic [18:0] cfg_delay,         // Operate delay in 5 ms steps
  input wire logic [18:0] cfg_pulse,         // Trip pulse length in 5 ms steps
  input wire logic [14:0] cfg_release,       // Release time in 5 ms steps
  input wire logic cfg_dly_release,          // Delayed pick-up release enable
  input wire logic cfg_rst_after_release,    // Timer reset after release time
  input wire logic cnt_clear,                // Clear all cumulative counters
  output logic start,                        // Start output
  output logic trip,                         // Trip output
  output logic trip_pulse,                   // Trip pulse output
  output logic blocked,                      // Blocked output
  output rvp_pkg::rvp_status_t status,       // Stage status code
  output logic evt_valid,                    // Event record valid, one cycle
  output logic [7:0] evt_flags,              // Event kinds in this record
  output logic [31:0] evt_stamp,             // Event time in ms
  output logic [VW-1:0] evt_voltage,         // Voltage at the event
  output logic [VW-1:0] evt_prefault,        // Averaged pre-fault voltage
  output logic evt_fault_under,              // Fault type, 1 for undervoltage
  output logic disp_event,                   // Display event on block activation
  output logic [15:0] cnt_start,             // Cumulative start count
  output logic [15:0] cnt_trip,              // Cumulative trip count
  output logic [15:0] cnt_blocked            // Cumulative blocked count
);
  localparam int HIST = 2 * PREF_N;

  logic cyc_tick;
  logic ms_tick;
  rvp_pkg::rvp_group_t grp_reg [GROUPS];
  rvp_pkg::rvp_group_t g;
  rvp_pkg::rvp_group_t wr_g;
  logic [VW-1:0] v_sel;
  logic [31:0] v_x100, lvl_x97, lvl_x103;
  logic under;
  logic all_up;
  logic pick_reg, pick_next;
  logic deen_reg, deen_next;
  logic blocked_reg, blocked_next;
  logic eff;
  logic start_reg, trip_reg, trip_q;
  logic [18:0] op_reg;
  logic [14:0] rel_reg;
  logic [18:0] pulse_cnt_reg;
  logic [VW-1:0] hist_reg [HIST];
  logic [VW+7:0] pref_sum;
  logic [31:0] ms_reg;
  logic vis_start, vis_trip, vis_blocked, vis_pulse;
  rvp_pkg::rvp_status_t vis_status;

  rvp_tick_div #(.DIV(CYCLE_CLKS)) u_cycle (
    .core_clk(core_clk),
    .rstn(rstn),
    .tick(cyc_tick)
  );
  rvp_tick_div #(.DIV(STAMP_CLKS)) u_stamp (
    .core_clk(core_clk),
    .rstn(rstn),
    .tick(ms_tick)
  );

  // Out-of-range writes are clamped so the comparator never sees an illegal level
  always_comb begin
    wr_g.mode = cfg_mode;
    wr_g.pickup = (cfg_pickup_level > `RVP_PICKUP_MAX) ? `RVP_PICKUP_MAX : cfg_pickup_level;
    wr_g.blk_lvl = (cfg_deenergised_block_level > `RVP_BLKLVL_MAX) ? `RVP_BLKLVL_MAX :
                   cfg_deenergised_block_level;
    wr_g.delay = (cfg_delay > `RVP_TICKS_MAX) ? `RVP_TICKS_MAX : cfg_delay;
    wr_g.pulse = (cfg_pulse > `RVP_TICKS_MAX) ? `RVP_TICKS_MAX : cfg_pulse;
    wr_g.release_len = (cfg_release > `RVP_REL_MAX) ? `RVP_REL_MAX : cfg_release;
    wr_g.dly_release = cfg_dly_release;
    wr_g.rst_after_release = cfg_rst_after_release;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      for (int i = 0; i < GROUPS; i++) begin
        grp_reg[i].mode <= `RVP_MODE_OVER;
        grp_reg[i].pickup <= `RVP_PICKUP_RST;
        grp_reg[i].blk_lvl <= `RVP_BLKLVL_RST;
        grp_reg[i].delay <= `RVP_DELAY_RST;
        grp_reg[i].pulse <= `RVP_PULSE_RST;
        grp_reg[i].release_len <= `RVP_RELEASE_RST;
        grp_reg[i].dly_release <= 1'b1;
        grp_reg[i].rst_after_release <= 1'b1;
      end
    end else if (cfg_wr) begin
      grp_reg[cfg_group] <= wr_g;
    end
  end

  assign g = grp_reg[group_sel];
  assign under = (g.mode == `RVP_MODE_UNDER);

  always_comb begin
    case (channel_sel)
      `RVP_CHAN_B: v_sel = voltage_channel_b;
      `RVP_CHAN_C: v_sel = voltage_channel_c;
      `RVP_CHAN_D: v_sel = voltage_channel_d;
      default: v_sel = voltage_channel_a;
    endcase
  end

  // Scaled compares keep the hysteresis exact without a divider
  assign v_x100 = 32'(v_sel) * 32'(`RVP_PCT_FULL);
  assign lvl_x97 = 32'(g.pickup) * 32'(`RVP_OVER_PCT);
  assign lvl_x103 = 32'(g.pickup) * 32'(`RVP_UNDER_PCT);
  assign all_up = (voltage_channel_a >= VW'(g.pickup)) && (voltage_channel_b >= VW'(g.pickup)) &&
                  (voltage_channel_c >= VW'(g.pickup)) && (voltage_channel_d >= VW'(g.pickup));

  always_comb begin
    if (under) begin
      pick_next = pick_reg ? !(v_x100 > lvl_x103) : (v_sel < VW'(g.pickup));
    end else begin
      pick_next = pick_reg ? !(v_x100 < lvl_x97) : (v_sel > VW'(g.pickup));
    end
  end

  assign deen_next = under && (g.blk_lvl != 16'h0) &&
                     ((v_sel < VW'(g.blk_lvl)) || (deen_reg && !all_up));
  assign blocked_next = pick_next && (blocked_reg || block_in || deen_next);
  assign eff = pick_next && !blocked_next;

  // All protection state moves only on the processing tick
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pick_reg <= 1'b0;
      deen_reg <= 1'b0;
      blocked_reg <= 1'b0;
    end else if (cyc_tick) begin
      pick_reg <= pick_next;
      deen_reg <= deen_next;
      blocked_reg <= blocked_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      start_reg <= 1'b0;
      trip_reg <= 1'b0;
      op_reg <= '0;
      rel_reg <= '0;
    end else if (cyc_tick) begin
      if (eff) begin
        start_reg <= 1'b1;
        rel_reg <= '0;
        if (op_reg >= g.delay) begin
          trip_reg <= 1'b1;
        end else begin
          op_reg <= op_reg + 1'b1;
        end
      end else begin
        trip_reg <= 1'b0;
        // A block drops start at once, so start never stands beside blocked
        if (g.dly_release && start_reg && !blocked_next &&
            (rel_reg < g.release_len)) begin
          rel_reg <= rel_reg + 1'b1;
          if (!g.rst_after_release) begin
            op_reg <= '0;
          end
        end else begin
          start_reg <= 1'b0;
          rel_reg <= '0;
          op_reg <= '0;
        end
      end
    end
  end

  // Pulse length is independent of how long trip stays up
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      trip_q <= 1'b0;
      pulse_cnt_reg <= '0;
    end else begin
      trip_q <= trip_reg;
      if (trip_reg && !trip_q) begin
        pulse_cnt_reg <= g.pulse;
      end else if (cyc_tick && (pulse_cnt_reg != '0)) begin
        pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      for (int i = 0; i < HIST; i++) begin
        hist_reg[i] <= '0;
      end
    end else if (cyc_tick) begin
      hist_reg[0] <= v_sel;
      for (int i = 1; i < HIST; i++) begin
        hist_reg[i] <= hist_reg[i-1];
      end
    end
  end

  always_comb begin
    pref_sum = '0;
    for (int i = PREF_N; i < HIST; i++) begin
      pref_sum = pref_sum + (VW+8)'(hist_reg[i]);
    end
  end

  always_comb begin
    if (force_enable) begin
      vis_status = rvp_pkg::rvp_status_t'(status_override);
    end else if (blocked_reg) begin
      vis_status = rvp_pkg::rvp_st_blocked;
    end else if (trip_reg) begin
      vis_status = rvp_pkg::rvp_st_trip;
    end else if (start_reg) begin
      vis_status = rvp_pkg::rvp_st_start;
    end else begin
      vis_status = rvp_pkg::rvp_st_normal;
    end
    vis_start = force_enable ? ((vis_status == rvp_pkg::rvp_st_start) ||
                                (vis_status == rvp_pkg::rvp_st_trip)) : start_reg;
    vis_trip = force_enable ? (vis_status == rvp_pkg::rvp_st_trip) : trip_reg;
    vis_blocked = force_enable ? (vis_status == rvp_pkg::rvp_st_blocked) : blocked_reg;
    vis_pulse = (pulse_cnt_reg != '0);
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ms_reg <= '0;
    end else if (ms_tick) begin
      ms_reg <= ms_reg + 1'b1;
    end
  end

  // One record per change keeps simultaneous edges on a single time stamp
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      start <= 1'b0;
      trip <= 1'b0;
      blocked <= 1'b0;
      trip_pulse <= 1'b0;
      status <= rvp_pkg::rvp_st_normal;
      evt_valid <= 1'b0;
      evt_flags <= 8'h00;
      evt_stamp <= 32'h0;
      evt_voltage <= '0;
      evt_prefault <= '0;
      evt_fault_under <= 1'b0;
      disp_event <= 1'b0;
    end else begin
      start <= vis_start;
      trip <= vis_trip;
      blocked <= vis_blocked;
      trip_pulse <= vis_pulse;
      status <= vis_status;
      evt_flags[`RVP_EV_START_ON] <= vis_start && !start;
      evt_flags[`RVP_EV_START_OFF] <= !vis_start && start;
      evt_flags[`RVP_EV_TRIP_ON] <= vis_trip && !trip;
      evt_flags[`RVP_EV_TRIP_OFF] <= !vis_trip && trip;
      evt_flags[`RVP_EV_BLK_ON] <= vis_blocked && !blocked;
      evt_flags[`RVP_EV_BLK_OFF] <= !vis_blocked && blocked;
      evt_flags[`RVP_EV_PULSE_ON] <= vis_pulse && !trip_pulse;
      evt_flags[`RVP_EV_PULSE_OFF] <= !vis_pulse && trip_pulse;
      evt_valid <= (vis_start != start) || (vis_trip != trip) ||
                   (vis_blocked != blocked) || (vis_pulse != trip_pulse);
      evt_stamp <= ms_reg;
      evt_voltage <= v_sel;
      evt_prefault <= VW'(pref_sum / (VW+8)'(PREF_N));
      evt_fault_under <= under;
      disp_event <= vis_blocked && !blocked;
    end
  end

  // A rising edge in the clearing cycle is still counted
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_start <= 16'h0;
      cnt_trip <= 16'h0;
      cnt_blocked <= 16'h0;
    end else begin
      cnt_start <= (cnt_clear ? 16'h0 : cnt_start) + 16'(vis_start && !start);
      cnt_trip <= (cnt_clear ? 16'h0 : cnt_trip) + 16'(vis_trip && !trip);
      cnt_blocked <= (cnt_clear ? 16'h0 : cnt_blocked) + 16'(vis_blocked && !blocked);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_over_hyst;
    cyc_tick && !under && pick_reg && (v_x100 >= lvl_x97) |=> pick_reg;
  endproperty
  a_over_hyst: assert property (p_over_hyst) else $error("over pick-up released early");

  property p_under_hyst;
    cyc_tick && under && pick_reg && (v_x100 <= lvl_x103) |=> pick_reg;
  endproperty
  a_under_hyst: assert property (p_under_hyst) else $error("under pick-up released early");

  property p_trip_has_start;
    trip_reg |-> start_reg && !blocked_reg;
  endproperty
  a_trip_has_start: assert property (p_trip_has_start) else $error("trip without start");

  property p_block_at_pickup;
    cyc_tick && block_in && pick_next && !pick_reg |=> blocked_reg && !trip_reg;
  endproperty
  a_block_at_pickup: assert property (p_block_at_pickup) else $error("block ignored");

  property p_deen_off;
    (g.blk_lvl == 16'h0) |-> !deen_next;
  endproperty
  a_deen_off: assert property (p_deen_off) else $error("de-energised block at zero");

  property p_deen_no_trip;
    cyc_tick && deen_next |=> !trip_reg;
  endproperty
  a_deen_no_trip: assert property (p_deen_no_trip) else $error("trip while de-energised");

  property p_instant;
    cyc_tick && eff && (g.delay == 19'h0) |=> trip_reg && start_reg;
  endproperty
  a_instant: assert property (p_instant) else $error("instant trip missing");

  property p_tick_only;
    !cyc_tick |=> $stable(start_reg) && $stable(trip_reg) && $stable(blocked_reg);
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("state moved off tick");

  property p_pulse_load;
    trip_reg && !trip_q |=> pulse_cnt_reg == $past(g.pulse);
  endproperty
  a_pulse_load: assert property (p_pulse_load) else $error("pulse length wrong");

  property p_same_stamp;
    vis_start && !start && vis_trip && !trip |=>
      evt_valid && evt_flags[`RVP_EV_START_ON] && evt_flags[`RVP_EV_TRIP_ON];
  endproperty
  a_same_stamp: assert property (p_same_stamp) else $error("start and trip split");

  property p_ms_count;
    ms_tick |=> ms_reg == $past(ms_reg) + 32'h1;
  endproperty
  a_ms_count: assert property (p_ms_count) else $error("time stamp not advancing");

  property p_cnt_start;
    vis_start && !start && !cnt_clear |=> cnt_start == $past(cnt_start) + 16'h1;
  endproperty
  a_cnt_start: assert property (p_cnt_start) else $error("start count missed");

  c_trip: cover property (cyc_tick ##1 $rose(trip_reg));
  c_blocked: cover property ($rose(blocked_reg) ##1 disp_event);
  c_deen: cover property ($rose(deen_reg));
  c_pulse_end: cover property ($fell(trip_pulse) && trip);
endmodule

// ==== rvp_cfg.svh ====
// Timing, field and reset constants for the railway voltage protection stage
`ifndef RVP_CFG_SVH
`define RVP_CFG_SVH
`define RVP_CLK_KHZ 100000
`define RVP_CYCLE_MS 5
`define RVP_STAMP_MS 1
`define RVP_PREF_MS 20
`define RVP_PREF_SAMPLES (`RVP_PREF_MS / `RVP_CYCLE_MS)
`define RVP_GROUPS 8
`define RVP_OVER_PCT 97
`define RVP_UNDER_PCT 103
`define RVP_PCT_FULL 100
`define RVP_PICKUP_MAX 16'h3a98
`define RVP_BLKLVL_MAX 16'h1f40
`define RVP_PICKUP_RST 16'h07d0
`define RVP_BLKLVL_RST 16'h0000
`define RVP_MODE_OVER 2'h1
`define RVP_MODE_UNDER 2'h2
`define RVP_CHAN_A 3'h1
`define RVP_CHAN_B 3'h2
`define RVP_CHAN_C 3'h3
`define RVP_CHAN_D 3'h4
`define RVP_TICKS_MAX 19'h57e40
`define RVP_REL_MAX 15'h7530
`define RVP_DELAY_MS 40
`define RVP_PULSE_MS 100
`define RVP_RELEASE_MS 60
`define RVP_DELAY_RST 19'(`RVP_DELAY_MS / `RVP_CYCLE_MS)
`define RVP_PULSE_RST 19'(`RVP_PULSE_MS / `RVP_CYCLE_MS)
`define RVP_RELEASE_RST 15'(`RVP_RELEASE_MS / `RVP_CYCLE_MS)
`define RVP_EV_START_ON 0
`define RVP_EV_START_OFF 1
`define RVP_EV_TRIP_ON 2
`define RVP_EV_TRIP_OFF 3
`define RVP_EV_BLK_ON 4
`define RVP_EV_BLK_OFF 5
`define RVP_EV_PULSE_ON 6
`define RVP_EV_PULSE_OFF 7
`endif

// ==== rvp_pkg.sv ====
// Types shared by the railway voltage protection stage
package rvp_pkg;
  typedef enum logic [1:0] {
    rvp_st_normal,
    rvp_st_start,
    rvp_st_trip,
    rvp_st_blocked
  } rvp_status_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [15:0] pickup;
    logic [15:0] blk_lvl;
    logic [18:0] delay;
    logic [18:0] pulse;
    logic [14:0] release_len;
    logic dly_release;
    logic rst_after_release;
  } rvp_group_t;
endpackage

// ==== rvp_tick_div.sv ====
// Divider that gives a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
module rvp_tick_div #(
  parameter int DIV = 500000
) (
  input wire logic core_clk, // System clock
  input wire logic rstn,     // Synchronous reset, active low
  output logic tick          // One-cycle pulse every DIV clocks
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  logic [CW-1:0] cnt_reg;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else if (cnt_reg == CW'(DIV - 1)) begin
      cnt_reg <= '0;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule

// ==== rvp_meas_model.sv ====
// Model of the voltage measurement front end and the blocking matrix
`timescale 1ns/1ps
module rvp_meas_model #(
  parameter int VW = 24
) (
  input wire logic core_clk,              // System clock
  output logic [VW-1:0] voltage_channel_a, // RMS voltage a
  output logic [VW-1:0] voltage_channel_b, // RMS voltage b
  output logic [VW-1:0] voltage_channel_c, // RMS voltage c
  output logic [VW-1:0] voltage_channel_d, // RMS voltage d
  output logic block_in                    // Blocking matrix output
);
  initial begin
    {voltage_channel_a, voltage_channel_b} = {2{24'h0007d0}};
    {voltage_channel_c, voltage_channel_d} = {2{24'h0007d0}};
    block_in = 1'b0;
  end
  // Values stand until the next call, so each spans whole 5 ms updates
  task automatic set_v(input logic [VW-1:0] a, b, c, d);
    @(posedge core_clk);
    #1;
    {voltage_channel_a, voltage_channel_b, voltage_channel_c, voltage_channel_d} = {a, b, c, d};
  endtask
  // Callers raise the block ticks before any operate delay can run out
  task automatic set_blk(input logic b);
    @(posedge core_clk);
    #1;
    block_in = b;
  endtask
endmodule

// ==== rvp_stage_tb_top.sv ====
// Self-checking bench for the railway voltage protection stage
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module rvp_stage_tb_top;
  localparam int CYC = 20;
  localparam int MSC = 4;
  localparam int LIMIT = 40000;
  logic core_clk = 1'b0;
  logic rstn;
  logic [23:0] va, vb, vc, vd, v_exp;
  logic blk_in;
  logic [2:0] channel_sel;
  logic force_enable;
  logic [1:0] status_override;
  logic [2:0] group_sel;
  logic cfg_wr;
  logic [2:0] cfg_group;
  logic [1:0] cfg_mode;
  logic [15:0] cfg_pickup_level;
  logic [15:0] cfg_blk;
  logic [18:0] cfg_delay;
  logic [18:0] cfg_pulse;
  logic [14:0] cfg_release;
  logic cfg_dly_release;
  logic cfg_rst_after_release;
  logic cnt_clear;
  logic start, trip, trip_pulse, blocked, evt_valid, evt_fault_under, disp_event;
  rvp_pkg::rvp_status_t status;
  logic [7:0] evt_flags;
  logic [15:0] cnt_start, cnt_trip, cnt_blocked;
  logic [7:0] exp_q[$];
  logic [7:0] exp_now;
  logic [31:0] evt_stamp;
  logic [23:0] evt_voltage, evt_prefault;
  logic pref_on;
  int bad_count = 0;
  int checked = 0;
  int cyc_n = 0;
  int r;

  always #5 core_clk = ~core_clk;

  // Voltage the stage should be reading for the current channel code
  assign v_exp = (channel_sel == 3'h2) ? vb : (channel_sel == 3'h3) ? vc :
                 (channel_sel == 3'h4) ? vd : va;

  rvp_meas_model u_rvp_meas_model (.core_clk(core_clk), .voltage_channel_a(va),
    .voltage_channel_b(vb), .voltage_channel_c(vc), .voltage_channel_d(vd), .block_in(blk_in));

  rvp_stage #(.CYCLE_CLKS(CYC), .STAMP_CLKS(MSC)) u_rvp_stage (.core_clk(core_clk), .rstn(rstn),
    .voltage_channel_a(va), .voltage_channel_b(vb), .voltage_channel_c(vc),
    .voltage_channel_d(vd), .channel_sel(channel_sel), .block_in(blk_in),
    .force_enable(force_enable), .status_override(status_override), .group_sel(group_sel),
    .cfg_wr(cfg_wr), .cfg_group(cfg_group), .cfg_mode(cfg_mode),
    .cfg_pickup_level(cfg_pickup_level), .cfg_deenergised_block_level(cfg_blk),
    .cfg_delay(cfg_delay), .cfg_pulse(cfg_pulse), .cfg_release(cfg_release),
    .cfg_dly_release(cfg_dly_release), .cfg_rst_after_release(cfg_rst_after_release),
    .cnt_clear(cnt_clear), .start(start), .trip(trip), .trip_pulse(trip_pulse),
    .blocked(blocked), .status(status), .evt_valid(evt_valid), .evt_flags(evt_flags),
    .evt_stamp(evt_stamp), .evt_voltage(evt_voltage), .evt_prefault(evt_prefault),
    .evt_fault_under(evt_fault_under),
    .disp_event(disp_event), .cnt_start(cnt_start), .cnt_trip(cnt_trip),
    .cnt_blocked(cnt_blocked));

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Each record is matched against the oldest pending note, or against zero flags when none is pending
  always @(negedge core_clk) begin
    if (evt_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        exp_now = 8'h00;
      end else begin
        exp_now = exp_q.pop_front();
      end
      `CHK(evt_flags, exp_now)
      `CHK(disp_event, exp_now[4])
      // Stamp counts ms ticks from the first edge out of reset
      `CHK(evt_stamp, 32'((cyc_n - 6) / MSC))
      `CHK(evt_voltage, v_exp)
      `CHK(evt_fault_under, cfg_mode == 2'h2)
      if (pref_on) begin
        `CHK(evt_prefault, 24'h000640)
      end
    end
  end

  always @(posedge core_clk) begin
    cyc_n++;
    if (cyc_n == LIMIT) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic ticks(input int n);
    repeat (n * CYC) @(posedge core_clk);
    #1;
  endtask

  task automatic cfg(input logic [2:0] g, input logic [1:0] m, input logic [15:0] p, b,
                     input logic [18:0] d, pl, input logic dr);
    @(posedge core_clk);
    #1;
    {cfg_wr, cfg_group, cfg_mode, cfg_pickup_level, cfg_blk} = {1'b1, g, m, p, b};
    {cfg_delay, cfg_pulse, cfg_dly_release} = {d, pl, dr};
    @(posedge core_clk);
    #1;
    cfg_wr = 1'b0;
  endtask

  task automatic v_all(input logic [23:0] v);
    u_rvp_meas_model.set_v(v, v, v, v);
  endtask

  initial begin
    rstn = 1'b0;
    {force_enable, status_override, group_sel, cfg_wr, cfg_group, cnt_clear} = 11'h000;
    {channel_sel, cfg_mode, cfg_pickup_level, cfg_blk} = {3'h1, 2'h1, 16'h07d0, 16'h0000};
    {cfg_delay, cfg_pulse, cfg_release} = {19'h0, 19'h0, 15'h000c};
    {cfg_dly_release, cfg_rst_after_release, pref_on} = 3'b010;
    void'($urandom(96322));
    repeat (4) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    cnt_clear = 1'b1;
    ticks(2);
    cnt_clear = 1'b0;
    cfg(3'h0, 2'h1, 16'h07d0, 16'h0, 19'h0, 19'h2, 1'b0);
    exp_q.push_back(8'h05);
    exp_q.push_back(8'h40);
    exp_q.push_back(8'h80);
    v_all(24'h0008fc);
    ticks(6);
    v_all(24'h00079e); // 1950 stays picked up
    ticks(3);
    exp_q.push_back(8'h0a);
    v_all(24'h00078a);
    ticks(3);
    $display("Test over-level done");
    cfg_release = 15'h0003;
    cfg_rst_after_release = 1'($urandom % 2);
    cfg(3'h0, 2'h1, 16'h07d0, 16'h0, 19'h4, 19'h0, 1'b1);
    exp_q.push_back(8'h01);
    exp_q.push_back(8'h02);
    v_all(24'h0008fc);
    ticks(2);
    v_all(24'h000640);
    ticks(2);
    `CHK(start, 1'b1)
    `CHK(status, rvp_pkg::rvp_st_start)
    ticks(3);
    `CHK(start, 1'b0)
    $display("Test delayed release done");
    // Under pick-up 1500 keeps 1600 neutral across the mode switch
    cfg(3'h0, 2'h2, 16'h05dc, 16'h0, 19'h2, 19'h0, 1'b0);
    exp_q.push_back(8'h01);
    exp_q.push_back(8'h04);
    v_all(24'h0005d2);
    ticks(4);
    v_all(24'h000604); // 1540 stays picked up
    ticks(3);
    exp_q.push_back(8'h0a);
    v_all(24'h00060e);
    ticks(3);
    $display("Test under-level done");
    cfg(3'h0, 2'h2, 16'h05dc, 16'h01f4, 19'h2, 19'h0, 1'b0);
    exp_q.push_back(8'h10);
    v_all(24'h00012c);
    ticks(3);
    exp_q.push_back(8'h20);
    u_rvp_meas_model.set_v(24'h000640, 24'h00012c, 24'h00012c, 24'h00012c);
    ticks(3);
    // Above the block level but other lines still low: the block must come back
    exp_q.push_back(8'h10);
    u_rvp_meas_model.set_v(24'h0003e8, 24'h00012c, 24'h00012c, 24'h00012c);
    ticks(3);
    exp_q.push_back(8'h20);
    v_all(24'h000640);
    ticks(3);
    $display("Test de-energised block done");
    cfg(3'h0, 2'h1, 16'h07d0, 16'h0, 19'h0, 19'h0, 1'b0);
    u_rvp_meas_model.set_blk(1'b1);
    exp_q.push_back(8'h10);
    v_all(24'h0008fc);
    ticks(3);
    exp_q.push_back(8'h20);
    v_all(24'h000640);
    ticks(3);
    u_rvp_meas_model.set_blk(1'b0);
    cfg(3'h0, 2'h1, 16'h07d0, 16'h0, 19'h64, 19'h0, 1'b0);
    exp_q.push_back(8'h01);
    v_all(24'h0008fc);
    ticks(3);
    exp_q.push_back(8'h12);
    u_rvp_meas_model.set_blk(1'b1);
    ticks(3);
    exp_q.push_back(8'h20);
    v_all(24'h000640);
    ticks(3);
    u_rvp_meas_model.set_blk(1'b0);
    $display("Test external block done");
    cfg(3'h3, 2'h1, 16'h07d0, 16'h0, 19'h0, 19'h0, 1'b0);
    group_sel = 3'h3;
    for (int s = 1; s <= 4; s++) begin
      channel_sel = 3'(s);
      r = 2001 + ($urandom % 1000);
      exp_q.push_back(8'h05);
      u_rvp_meas_model.set_v(s == 1 ? 24'(r) : 24'h000640, s == 2 ? 24'(r) : 24'h000640,
                             s == 3 ? 24'(r) : 24'h000640, s == 4 ? 24'(r) : 24'h000640);
      ticks(3);
      exp_q.push_back(8'h0a);
      v_all(24'h000640);
      ticks(3);
    end
    $display("Test channel select done");
    `CHK(cnt_start, 16'h0008)
    `CHK(cnt_trip, 16'h0006)
    `CHK(cnt_blocked, 16'h0004)
    `CHK(exp_q.size(), 0)
    // Let the pre-fault window fill with one steady value
    ticks(8);
    pref_on = 1'b1;
    force_enable = 1'b1;
    for (int k = 0; k < 4; k++) begin
      if (k > 0) begin
        exp_q.push_back(k == 1 ? 8'h01 : (k == 2 ? 8'h04 : 8'h1a));
      end
      status_override = 2'(k);
      ticks(2);
      `CHK(status, rvp_pkg::rvp_status_t'(k))
    end
    exp_q.push_back(8'h20);
    force_enable = 1'b0;
    ticks(2);
    `CHK(exp_q.size(), 0)
    `CHK(cnt_blocked, 16'h0005)
    $display("Test forcing done");
    print_verdict();
  end
endmodule
